// ### hdl/pdg_diag_regs.sv
// Diagnostics / pin mux register bank of the transceiver.
// Assumes a 16-bit management access strobe on mclk: the space select tells
// the indirect pcs space from the extended space; reads answer combinationally.
//
// Functional notes
// - Pin one select, bits 7:4, codes listed.
// - Pin zero select same, code zero receive error.
// - Bit 12 skips channels C and D.
// - Bit 11 listens only on transmit channel.
// - Bit 10, reset one, checks silence pulses.
// - Averaging code 111 clears the field, reads zero.
// - Segment count bits 6:4, reset 101.
// - Cycle duration bits 3:0, reset 010.
// - Diagnostic result and completion flag read-only.
// - Clear bit resets stored diagnostic results.
// - Pcs_space_reset reloads the pin select and reflectometry config reset values.
// - Pcs_space_reset then triggers a soft reset.
// - Pcs control bits 14:0 read zero.
`timescale 1ns/1ns
`default_nettype none
`include "pdg_regs.svh"

module pdg_diag_regs (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Management access
	input  wire logic        reg_sel_pcs,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_hit,
	// Pin event sources, mclk domain
	input  wire logic        ev_col,
	input  wire logic        ev_rx_err,
	input  wire logic        ev_tx_sfd,
	input  wire logic        ev_rx_sfd,
	input  wire logic        ev_wake,
	input  wire logic        ev_energy,
	input  wire logic        ev_led3,
	input  wire logic        ev_prbs,
	// Pins
	output logic             gp_pin0,
	output logic             gp_pin1,
	// Reflectometry engine settings
	output logic             skip_channels_c_d,
	output logic             cross_listen_disable,
	output logic             silence_pulse_check,
	output logic      [2:0]  reflect_average_count,
	output logic      [2:0]  reflect_segment_count,
	output logic      [3:0]  reflect_cycle_duration,
	// Link diagnostic engine
	input  wire logic        link_diag_result_valid,
	input  wire logic [7:0]  link_diag_result_in,
	input  wire logic        link_diag_complete_in,
	output logic             link_diag_result_clear,
	// Resets toward the device
	output logic             pcs_space_reset,
	output logic             basic_mode_control_soft_reset
);
	import pdg_pkg::*;

	logic [3:0] pin0_sel_q;
	logic [3:0] pin1_sel_q;
	logic       skip_cd_q;
	logic       cross_dis_q;
	logic       silence_q;
	logic [2:0] avg_q;
	logic [2:0] seg_q;
	logic [3:0] dur_q;
	logic [7:0] ldiag_res_q;
	logic       ldiag_done_q;
	logic       ldiag_clr_q;
	logic       pcs_busy;

	logic hit_pin;
	logic hit_refl;
	logic hit_ldiag;
	logic hit_pcs;
	logic wr_ldiag_clr;
	logic wr_pcs_rst;

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	assign hit_pin   = !reg_sel_pcs && reg_addr == `PDG_OFS_PIN_SEL;
	assign hit_refl  = !reg_sel_pcs && reg_addr == `PDG_OFS_REFL_CFG;
	assign hit_ldiag = !reg_sel_pcs && reg_addr == `PDG_OFS_LDIAG_CTRL;
	// Only visible through the indirect space select
	assign hit_pcs   = reg_sel_pcs && reg_addr == `PDG_OFS_PCS_CTRL;
	assign reg_hit   = (reg_wr || reg_rd) && (hit_pin || hit_refl || hit_ldiag || hit_pcs);

	assign wr_ldiag_clr = reg_wr && hit_ldiag && reg_wdata[`PDG_LDIAG_CLR_BIT];
	assign wr_pcs_rst   = reg_wr && hit_pcs && reg_wdata[`PDG_PCS_RST_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Pin select register

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin0_sel_q <= `PDG_PIN_SEL_RST;
			pin1_sel_q <= `PDG_PIN_SEL_RST;
		end else if (pcs_space_reset) begin
			pin0_sel_q <= `PDG_PIN_SEL_RST;
			pin1_sel_q <= `PDG_PIN_SEL_RST;
		end else if (reg_wr && hit_pin) begin
			pin1_sel_q <= reg_wdata[`PDG_PIN1_MSB:`PDG_PIN1_LSB];
			pin0_sel_q <= reg_wdata[`PDG_PIN0_MSB:`PDG_PIN0_LSB];
		end
	end

	pdg_pin_mux u_pin0 (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sel       (pin0_sel_q),
		.ev_code0  (ev_rx_err),
		.ev_tx_sfd (ev_tx_sfd),
		.ev_rx_sfd (ev_rx_sfd),
		.ev_wake   (ev_wake),
		.ev_energy (ev_energy),
		.ev_led3   (ev_led3),
		.ev_prbs   (ev_prbs),
		.pin_q     (gp_pin0)
	);

	pdg_pin_mux u_pin1 (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sel       (pin1_sel_q),
		.ev_code0  (ev_col),
		.ev_tx_sfd (ev_tx_sfd),
		.ev_rx_sfd (ev_rx_sfd),
		.ev_wake   (ev_wake),
		.ev_energy (ev_energy),
		.ev_led3   (ev_led3),
		.ev_prbs   (ev_prbs),
		.pin_q     (gp_pin1)
	);

	////////////////////////////////////////////////////////////////////////////
	// Reflectometry configuration

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			skip_cd_q   <= `PDG_REFL_SKIP_RST;
			cross_dis_q <= `PDG_REFL_CROSS_RST;
			silence_q   <= `PDG_REFL_SILENCE_RST;
			avg_q       <= `PDG_REFL_AVG_RST;
			seg_q       <= `PDG_REFL_SEG_RST;
			dur_q       <= `PDG_REFL_DUR_RST;
		end else if (pcs_space_reset) begin
			skip_cd_q   <= `PDG_REFL_SKIP_RST;
			cross_dis_q <= `PDG_REFL_CROSS_RST;
			silence_q   <= `PDG_REFL_SILENCE_RST;
			avg_q       <= `PDG_REFL_AVG_RST;
			seg_q       <= `PDG_REFL_SEG_RST;
			dur_q       <= `PDG_REFL_DUR_RST;
		end else if (reg_wr && hit_refl) begin
			skip_cd_q   <= reg_wdata[`PDG_REFL_SKIP_CD];
			cross_dis_q <= reg_wdata[`PDG_REFL_CROSS_DIS];
			silence_q   <= reg_wdata[`PDG_REFL_SILENCE_CHK];
			seg_q       <= reg_wdata[`PDG_REFL_SEG_MSB:`PDG_REFL_SEG_LSB];
			dur_q       <= reg_wdata[`PDG_REFL_DUR_MSB:`PDG_REFL_DUR_LSB];
			// Reserved code leaves the field cleared, not the old value
			if (reg_wdata[`PDG_REFL_AVG_MSB:`PDG_REFL_AVG_LSB] == `PDG_REFL_AVG_RSVD) begin
				avg_q <= 3'h0;
			end else begin
				avg_q <= reg_wdata[`PDG_REFL_AVG_MSB:`PDG_REFL_AVG_LSB];
			end
		end
	end

	assign skip_channels_c_d      = skip_cd_q;
	assign cross_listen_disable   = cross_dis_q;
	assign silence_pulse_check    = silence_q;
	assign reflect_average_count  = avg_q;
	assign reflect_segment_count  = seg_q;
	assign reflect_cycle_duration = dur_q;

	////////////////////////////////////////////////////////////////////////////
	// Link diagnostic result and clear

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ldiag_clr_q <= 1'b0;
		end else begin
			// One-cycle pulse, so the bit reads one in the cycle after the write, then zero
			ldiag_clr_q <= wr_ldiag_clr;
		end
	end

	assign link_diag_result_clear = ldiag_clr_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ldiag_res_q  <= 8'h00;
			ldiag_done_q <= 1'b0;
		end else if (link_diag_result_valid) begin
			// A fresh result wins over a clear in the same cycle
			ldiag_res_q  <= link_diag_result_in;
			ldiag_done_q <= link_diag_complete_in;
		end else if (wr_ldiag_clr) begin
			ldiag_res_q  <= 8'h00;
			ldiag_done_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pcs space reset chain

	pdg_pcs_space_reset u_pcs_rst (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.start       (wr_pcs_rst && !pcs_busy),
		.busy        (pcs_busy),
		.space_rst_q (pcs_space_reset),
		.soft_rst_q  (basic_mode_control_soft_reset)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read data

	always_comb begin
		reg_rdata = 16'h0000;
		if (reg_rd) begin
			if (hit_pin) begin
				reg_rdata[`PDG_PIN1_MSB:`PDG_PIN1_LSB] = pin1_sel_q;
				reg_rdata[`PDG_PIN0_MSB:`PDG_PIN0_LSB] = pin0_sel_q;
			end else if (hit_refl) begin
				reg_rdata[`PDG_REFL_SKIP_CD]                   = skip_cd_q;
				reg_rdata[`PDG_REFL_CROSS_DIS]                 = cross_dis_q;
				reg_rdata[`PDG_REFL_SILENCE_CHK]               = silence_q;
				reg_rdata[`PDG_REFL_AVG_MSB:`PDG_REFL_AVG_LSB] = avg_q;
				reg_rdata[`PDG_REFL_SEG_MSB:`PDG_REFL_SEG_LSB] = seg_q;
				reg_rdata[`PDG_REFL_DUR_MSB:`PDG_REFL_DUR_LSB] = dur_q;
			end else if (hit_ldiag) begin
				reg_rdata[`PDG_LDIAG_RES_MSB:`PDG_LDIAG_RES_LSB] = ldiag_res_q;
				reg_rdata[`PDG_LDIAG_DONE_BIT]                   = ldiag_done_q;
				reg_rdata[`PDG_LDIAG_CLR_BIT]                    = ldiag_clr_q;
			end else if (hit_pcs) begin
				// Reset bit reads one only while the chain runs
				reg_rdata[`PDG_PCS_RST_BIT] = pcs_busy;
			end
		end
	end

endmodule : pdg_diag_regs

`default_nettype wire

// ### hdl/pdg_pcs_space_reset.sv
// Pcs space reset sequencer: space reset pulse, then soft reset request.
// Assumes start is a one-cycle pulse from the register write decode.
`timescale 1ns/1ns
`default_nettype none
`include "pdg_regs.svh"

module pdg_pcs_space_reset #(
	parameter int RST_CYCLES = `PDG_PCS_RST_CYCLES
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	// Request
	input  wire logic start,
	// Results
	output logic      busy,
	output logic      space_rst_q,
	output logic      soft_rst_q
);
	import pdg_pkg::*;

	initial begin
		if (RST_CYCLES < 1 || RST_CYCLES > 255) begin
			$error("RST_CYCLES out of range");
		end
	end

	pdg_pcs_rst_e state_q;
	logic [7:0]   cnt_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= PDG_PR_IDLE;
			cnt_q   <= 8'h00;
		end else begin
			unique case (state_q)
				PDG_PR_IDLE: begin
					if (start) begin
						state_q <= PDG_PR_SPACE;
						cnt_q   <= 8'(RST_CYCLES - 1);
					end
				end
				PDG_PR_SPACE: begin
					if (cnt_q == 8'h00) begin
						state_q <= PDG_PR_SOFT;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				PDG_PR_SOFT: state_q <= PDG_PR_IDLE;
				default:     state_q <= PDG_PR_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			space_rst_q <= 1'b0;
			soft_rst_q  <= 1'b0;
		end else begin
			space_rst_q <= (state_q == PDG_PR_IDLE && start) ||
			               (state_q == PDG_PR_SPACE && cnt_q != 8'h00);
			soft_rst_q  <= (state_q == PDG_PR_SPACE && cnt_q == 8'h00);
		end
	end

	assign busy = (state_q != PDG_PR_IDLE);

endmodule : pdg_pcs_space_reset

`default_nettype wire

// ### hdl/pdg_pin_mux.sv
// One general-purpose pin source selector.
// Assumes event inputs are already in the mclk domain.
`timescale 1ns/1ns
`default_nettype none

module pdg_pin_mux (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Selection
	input  wire logic [3:0] sel,
	// Events
	input  wire logic       ev_code0,
	input  wire logic       ev_tx_sfd,
	input  wire logic       ev_rx_sfd,
	input  wire logic       ev_wake,
	input  wire logic       ev_energy,
	input  wire logic       ev_led3,
	input  wire logic       ev_prbs,
	// Pin
	output logic            pin_q
);
	import pdg_pkg::*;

	logic pin_d;

	always_comb begin
		unique case (sel)
			PDG_SEL_COL_OR_RXER: pin_d = ev_code0;
			PDG_SEL_TX_SFD:      pin_d = ev_tx_sfd;
			PDG_SEL_RX_SFD:      pin_d = ev_rx_sfd;
			PDG_SEL_WAKE:        pin_d = ev_wake;
			PDG_SEL_ENERGY:      pin_d = ev_energy;
			PDG_SEL_LED3:        pin_d = ev_led3;
			PDG_SEL_PRBS:        pin_d = ev_prbs;
			PDG_SEL_CONST1:      pin_d = 1'b1;
			// Constant low and reserved codes
			default:             pin_d = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
		end
	end

endmodule : pdg_pin_mux

`default_nettype wire

// ### hdl/pdg_pkg.sv
// Types shared by the diagnostics / pin mux register bank.
// Assumes pdg_regs.svh supplies the numeric constants.
package pdg_pkg;

	// Pin event select codes
	typedef enum logic [3:0] {
		PDG_SEL_COL_OR_RXER = 4'h0,
		PDG_SEL_TX_SFD      = 4'h1,
		PDG_SEL_RX_SFD      = 4'h2,
		PDG_SEL_WAKE        = 4'h3,
		PDG_SEL_ENERGY      = 4'h4,
		PDG_SEL_RSVD5       = 4'h5,
		PDG_SEL_LED3        = 4'h6,
		PDG_SEL_PRBS        = 4'h7,
		PDG_SEL_CONST0      = 4'h8,
		PDG_SEL_CONST1      = 4'h9
	} pdg_pin_sel_e;

	// Pcs_space_reset sequencer states
	typedef enum logic [1:0] {
		PDG_PR_IDLE  = 2'b00,
		PDG_PR_SPACE = 2'b01,
		PDG_PR_SOFT  = 2'b10
	} pdg_pcs_rst_e;

endpackage : pdg_pkg

// ### hdl/pdg_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// diagnostics / pin mux register bank. Assumes a 16-bit management data path.
`ifndef PDG_REGS_SVH
`define PDG_REGS_SVH

// Offsets; pcs control is in the indirect space, the rest in the extended space
`define PDG_OFS_PCS_CTRL      16'h0000
`define PDG_OFS_PIN_SEL       16'h0172
`define PDG_OFS_REFL_CFG      16'h0180
`define PDG_OFS_LDIAG_CTRL    16'h01A7

// Pin select fields
`define PDG_PIN1_MSB          7
`define PDG_PIN1_LSB          4
`define PDG_PIN0_MSB          3
`define PDG_PIN0_LSB          0
`define PDG_PIN_SEL_RST       4'h0

// Reflectometry configuration fields
`define PDG_REFL_SKIP_CD      12
`define PDG_REFL_CROSS_DIS    11
`define PDG_REFL_SILENCE_CHK  10
`define PDG_REFL_AVG_MSB      9
`define PDG_REFL_AVG_LSB      7
`define PDG_REFL_SEG_MSB      6
`define PDG_REFL_SEG_LSB      4
`define PDG_REFL_DUR_MSB      3
`define PDG_REFL_DUR_LSB      0
`define PDG_REFL_SKIP_RST     1'h0
`define PDG_REFL_CROSS_RST    1'h0
`define PDG_REFL_SILENCE_RST  1'h1
`define PDG_REFL_AVG_RST      3'h6
`define PDG_REFL_AVG_RSVD     3'h7
`define PDG_REFL_SEG_RST      3'h5
`define PDG_REFL_DUR_RST      4'h2

// Link diagnostic control fields
`define PDG_LDIAG_RES_MSB     15
`define PDG_LDIAG_RES_LSB     8
`define PDG_LDIAG_DONE_BIT    5
`define PDG_LDIAG_CLR_BIT     4

// Pcs control field
`define PDG_PCS_RST_BIT       15

// Length of the pcs space reset pulse, in mclk cycles
`define PDG_PCS_RST_CYCLES    4

`endif

// ### verif/pdg_diag_asserts.sv
// Concurrent checks on the diagnostics register bank ports.
// Assumes binding to pdg_diag_regs, single mclk domain.
`timescale 1ns/1ns
`default_nettype none

module pdg_diag_asserts (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// Register access
	input wire logic        reg_sel_pcs,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// Pins, settings, resets
	input wire logic        ev_rx_err,
	input wire logic        gp_pin0,
	input wire logic        gp_pin1,
	input wire logic        skip_channels_c_d,
	input wire logic [2:0]  reflect_average_count,
	input wire logic        link_diag_result_clear,
	input wire logic        pcs_space_reset,
	input wire logic        basic_mode_control_soft_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Extended-space strobes; config writes during a space reset are lost
	wire wr_x = reg_wr && !reg_sel_pcs;
	wire rd_x = reg_rd && !reg_sel_pcs;
	wire cfg_wr = wr_x && reg_addr == 16'h0180 && !pcs_space_reset;
	wire pcs_go = reg_wr && reg_sel_pcs && reg_addr == 16'h0000 && reg_wdata[15];
	////////////////////////////////////////////////////////////////
	property p_pcs_seq;
		pcs_go && !pcs_space_reset && !basic_mode_control_soft_reset |=>
			pcs_space_reset[*4] ##1 (!pcs_space_reset && basic_mode_control_soft_reset);
	endproperty
	a_pcs_seq: assert property (p_pcs_seq) else $error("pcs_space_reset chain wrong");
	property p_soft_one;
		basic_mode_control_soft_reset |=> !basic_mode_control_soft_reset;
	endproperty
	a_soft_one: assert property (p_soft_one) else $error("soft reset longer than one cycle");
	property p_pcs_rsvd;
		reg_rd && reg_sel_pcs && reg_addr == 16'h0000 |-> reg_rdata[14:0] == 15'h0000;
	endproperty
	a_pcs_rsvd: assert property (p_pcs_rsvd) else $error("pcs reserved bits not zero");
	property p_clr_seq;
		wr_x && reg_addr == 16'h01A7 && reg_wdata[4] |=> link_diag_result_clear;
	endproperty
	a_clr_seq: assert property (p_clr_seq) else $error("clear pulse missing");
	property p_avg;
		cfg_wr |=> reflect_average_count == ((&$past(reg_wdata[9:7])) ? 3'h0 : $past(reg_wdata[9:7]));
	endproperty
	a_avg: assert property (p_avg) else $error("average count wrong");
	property p_skip;
		cfg_wr |=> skip_channels_c_d == $past(reg_wdata[12]);
	endproperty
	a_skip: assert property (p_skip) else $error("skip setting wrong");
	property p_pin_const;
		rd_x && reg_addr == 16'h0172 && reg_rdata[7:4] == 4'h9 |=> gp_pin1;
	endproperty
	a_pin_const: assert property (p_pin_const) else $error("pin one not high");
	property p_pin_rxer;
		rd_x && reg_addr == 16'h0172 && reg_rdata[3:0] == 4'h0 |=> gp_pin0 == $past(ev_rx_err);
	endproperty
	a_pin_rxer: assert property (p_pin_rxer) else $error("pin zero not receive error");
	property p_space_hold;
		pcs_space_reset && $past(pcs_space_reset) && rd_x && reg_addr == 16'h0180 |-> reg_rdata == 16'h0752;
	endproperty
	a_space_hold: assert property (p_space_hold) else $error("config not held at reset");
endmodule : pdg_diag_asserts

bind pdg_diag_regs pdg_diag_asserts u_chk (.mclk, .rst_n, .reg_sel_pcs, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata, .ev_rx_err, .gp_pin0, .gp_pin1, .skip_channels_c_d, .reflect_average_count,
	.link_diag_result_clear, .pcs_space_reset, .basic_mode_control_soft_reset);

`default_nettype wire

// ### verif/pdg_diag_regs_tb.sv
// Self-checking bench for the diagnostics register bank.
// Assumes the checker binds itself; inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none

module pdg_diag_regs_tb;
	logic        mclk, rst_n, reg_sel_pcs, reg_wr, reg_rd;
	logic [15:0] reg_addr, reg_wdata, d;
	logic        ev_col, ev_rx_err, ev_tx_sfd, ev_rx_sfd, ev_wake, ev_energy, ev_led3, ev_prbs;
	logic        link_diag_result_valid, link_diag_complete_in;
	logic [7:0]  link_diag_result_in;
	wire  [15:0] reg_rdata;
	wire         reg_hit, gp_pin0, gp_pin1, skip_channels_c_d, cross_listen_disable, silence_pulse_check;
	wire  [2:0]  reflect_average_count, reflect_segment_count;
	wire  [3:0]  reflect_cycle_duration;
	wire         link_diag_result_clear, pcs_space_reset, basic_mode_control_soft_reset;
	logic [15:0] m_refl;
	int          mismatches, total_checks, cycles, seed, i, k;

	pdg_diag_regs DUT (.mclk, .rst_n, .reg_sel_pcs, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.reg_hit, .ev_col, .ev_rx_err, .ev_tx_sfd, .ev_rx_sfd, .ev_wake, .ev_energy, .ev_led3, .ev_prbs,
		.gp_pin0, .gp_pin1, .skip_channels_c_d, .cross_listen_disable, .silence_pulse_check,
		.reflect_average_count, .reflect_segment_count, .reflect_cycle_duration, .link_diag_result_valid,
		.link_diag_result_in, .link_diag_complete_in, .link_diag_result_clear, .pcs_space_reset,
		.basic_mode_control_soft_reset);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Each access task sets both strobes once, so none is driven twice per step
	task automatic wr(input logic s, input logic [15:0] a, input logic [15:0] v);
		reg_wr = 1'b1;
		reg_rd = 1'b0;
		reg_sel_pcs = s;
		reg_addr = a;
		reg_wdata = v;
		@(negedge mclk);
	endtask : wr

	task automatic rd(input logic s, input logic [15:0] a, input logic [15:0] e);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		reg_sel_pcs = s;
		reg_addr = a;
		#10 chk($sformatf("rdata_%h", a), e, reg_rdata);
		@(negedge mclk);
	endtask : rd

	task automatic cfg;
		chk("cfg", {3'h0, m_refl[12:0]}, {3'h0, skip_channels_c_d, cross_listen_disable, silence_pulse_check,
			reflect_average_count, reflect_segment_count, reflect_cycle_duration});
	endtask : cfg

	function automatic logic pexp(input logic [3:0] c, input logic z);
		case (c)
			4'h0: pexp = z ? ev_rx_err : ev_col;
			4'h1: pexp = ev_tx_sfd;
			4'h2: pexp = ev_rx_sfd;
			4'h3: pexp = ev_wake;
			4'h4: pexp = ev_energy;
			4'h6: pexp = ev_led3;
			4'h7: pexp = ev_prbs;
			4'h9: pexp = 1'b1;
			default: pexp = 1'b0;
		endcase
	endfunction : pexp

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, reg_sel_pcs, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{ev_col, ev_rx_err, ev_tx_sfd, ev_rx_sfd, ev_wake, ev_energy, ev_led3, ev_prbs} = 8'h00;
		{link_diag_result_valid, link_diag_complete_in, link_diag_result_in} = '0;
		seed = 32'h7AD3;
		m_refl = 16'h0752;
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		rd(1'b0, 16'h0172, 16'h0000);
		rd(1'b0, 16'h0180, 16'h0752);
		rd(1'b0, 16'h01A7, 16'h0000);
		rd(1'b1, 16'h0000, 16'h0000);
		chk("hit", 16'h0001, {15'h0, reg_hit});
		cfg();
		rd(1'b0, 16'h0000, 16'h0000);
		chk("hit", 16'h0000, {15'h0, reg_hit});
		$display("reset values done");
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			d[9:7] = i[2:0];
			wr(1'b0, 16'h0180, d);
			m_refl = {3'h0, d[12:10], (i == 7) ? 3'h0 : d[9:7], d[6:0]};
			rd(1'b0, 16'h0180, m_refl);
			cfg();
		end
		wr(1'b1, 16'h0180, 16'h1FFF);
		rd(1'b0, 16'h0180, m_refl);
		$display("reflectometry config done");
		for (i = 0; i < 16; i++) begin
			{ev_col, ev_rx_err, ev_tx_sfd, ev_rx_sfd, ev_wake, ev_energy, ev_led3, ev_prbs} = $random(seed);
			k = (i + 3) % 16;
			d = $random(seed);
			d[7:0] = {k[3:0], i[3:0]};
			wr(1'b0, 16'h0172, d);
			rd(1'b0, 16'h0172, {8'h00, d[7:0]});
			chk("pin0", {15'h0, pexp(i[3:0], 1'b1)}, {15'h0, gp_pin0});
			chk("pin1", {15'h0, pexp(k[3:0], 1'b0)}, {15'h0, gp_pin1});
		end
		$display("pin select done");
		for (k = 0; k < 2; k++) begin
			link_diag_result_in = $random(seed);
			link_diag_complete_in = k[0];
			link_diag_result_valid = 1'b1;
			@(negedge mclk);
			link_diag_result_valid = 1'b0;
			rd(1'b0, 16'h01A7, {link_diag_result_in, 2'h0, k[0], 5'h00});
			wr(1'b0, 16'h01A7, 16'hFFFF);
			chk("clear", 16'h0001, {15'h0, link_diag_result_clear});
			rd(1'b0, 16'h01A7, 16'h0010);
			rd(1'b0, 16'h01A7, 16'h0000);
		end
		$display("link diagnostic done");
		wr(1'b1, 16'h0000, 16'hFFFF);
		for (i = 0; i < 4; i++) begin
			chk("resets", 16'h0002, {14'h0, pcs_space_reset, basic_mode_control_soft_reset});
			if (i % 2 == 0) begin
				// Bank reloads its reset values on the edge that ends the first pulse cycle
				rd(1'b0, 16'h0180, (i == 0) ? m_refl : 16'h0752);
			end else begin
				wr(1'b0, 16'h0180, 16'h0000);
			end
		end
		chk("resets", 16'h0001, {14'h0, pcs_space_reset, basic_mode_control_soft_reset});
		rd(1'b1, 16'h0000, 16'h8000);
		chk("resets", 16'h0000, {14'h0, pcs_space_reset, basic_mode_control_soft_reset});
		rd(1'b1, 16'h0000, 16'h0000);
		m_refl = 16'h0752;
		cfg();
		rd(1'b0, 16'h0172, 16'h0000);
		chk("pin1", {15'h0, ev_col}, {15'h0, gp_pin1});
		$display("pcs_space_reset done");
		end_of_test();
	end
endmodule : pdg_diag_regs_tb

`default_nettype wire
